//--- verilog/engine_status_pkg.sv
package engine_status_pkg;

	// -----------------------------------------------------------------
	// register map (byte offsets)
	// -----------------------------------------------------------------
	localparam logic [7:0] OFS_PAGE_BASE   = 8'h00;
	localparam logic [7:0] OFS_INT_STATUS  = 8'h04;
	localparam logic [7:0] OFS_INT_MASK    = 8'h08;
	localparam logic [7:0] OFS_INT_ENABLE  = 8'h0c;
	localparam logic [7:0] OFS_WRITE_MASK  = 8'h10;
	localparam logic [7:0] OFS_INT_IDENT   = 8'h14;
	localparam logic [7:0] OFS_ERR_STATUS  = 8'h18;
	localparam logic [7:0] OFS_ERR_MASK    = 8'h1c;
	localparam logic [7:0] OFS_ERR_IDENT   = 8'h20;
	localparam logic [7:0] OFS_CONTROL     = 8'h24;

	// -----------------------------------------------------------------
	// engine interrupt vector bit positions and the repair bit of the control register
	// -----------------------------------------------------------------
	localparam int BIT_USER      = 0;
	localparam int BIT_MASTER    = 3;
	localparam int BIT_FLUSH     = 4;
	localparam int BIT_PARITY    = 5;
	localparam int BIT_MEDIA_CNT = 6;
	localparam int BIT_PAGE_FLT  = 7;
	localparam int BIT_CTX_SW    = 8;
	localparam int BIT_REPAIR    = 0;

	// implemented bits of the vector; 1, 2 and 9 read zero
	localparam logic [31:0] ISR_VALID     = 32'h0000_01f9;
	// bits that may appear in a status page write
	localparam logic [31:0] REPORT_ALWAYS = 32'h0000_0008;
	localparam logic [31:0] REPORT_RENDER = 32'h0000_0020;
	// event bits cleared by software, level bits follow their source
	localparam logic [31:0] ISR_STICKY    = 32'h0000_0171;

	// -----------------------------------------------------------------
	// reset values and address fields
	// -----------------------------------------------------------------
	localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
	localparam logic [31:0] RST_ALL_MASK  = 32'hffff_ffff;
	localparam logic [31:0] PAGE_ALIGN    = 32'hffff_f000;
	localparam logic [31:0] ISR_SLOT_OFS  = 32'h0000_0000;

	// one status page write
	typedef struct packed {
		logic [31:0] addr;      // byte address in system memory
		logic [31:0] data;      // reported interrupt vector
		logic        snoop;     // always a snooped access
		logic        cacheable; // always cacheable
	} mem_write_s;

endpackage : engine_status_pkg

//--- verilog/engine_status_error_reporting.sv
// Behaviour
// R1: software aligns status page on 4KB
// R2: status reported by master writes to page
// R3: page accesses always cacheable and snooped
// R4: software keeps page out of unsnooped memory
// R5: page base comes from a software register
// R6: all interrupt registers share one bit layout
// R7: bit 8 context switch, never page reported
// R8: bit 7 page fault pending, never reported
// R9: repair mode raises fault ignoring mask
// R10: bit 6 media counter, media only, unreported
// R11: bit 5 parity, reported on render only
// R12: reported master error follows error presence
// R13: identity latches only unmasked error status
// R14: any identity error sets master error bit
// R15: identity bits clear by writing one, except unrecoverable
// R16: posted ops may overlap, complete eventually
// R17: non-posted op blocks next command until done
// R18: command flag selects posted or non-posted
// R19: page write includes only unmasked status bits
// R20: bits 4, 0 report zero; 9, 2 reserved
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps

module engine_status_error_reporting #(
	parameter bit          IS_RENDER    = 1'b1,  // engine is render pipe
	parameter bit          IS_MEDIA     = 1'b0,  // engine is media pipe
	parameter int          ERR_W        = 16,    // error vector width
	parameter logic [31:0] UNRECOV_MASK = 32'h0000_0001, // sticky errors
	parameter int          PEND_W       = 4      // outstanding op counter width
) (
	input  wire logic                        clock,        // 200 MHz
	input  wire logic                        reset_n,      // async reset
	input  wire logic                        wb_cyc_i,     // bus cycle
	input  wire logic                        wb_stb_i,     // strobe
	input  wire logic                        wb_we_i,      // write
	input  wire logic [7:0]                  wb_adr_i,     // byte address
	input  wire logic [3:0]                  wb_sel_i,     // byte lanes
	input  wire logic [31:0]                 wb_dat_i,     // write data
	output logic      [31:0]                 wb_dat_o,     // read data
	output logic                             wb_ack_o,     // acknowledge
	input  wire logic                        ev_user,      // user pulse
	input  wire logic                        ev_flush,     // flush pulse
	input  wire logic                        ev_parity,    // parity pulse
	input  wire logic                        ev_media_cnt, // counter pulse
	input  wire logic                        ev_ctx_sw,    // switch pulse
	input  wire logic                        pf_pending,   // fault level
	input  wire logic [ERR_W-1:0]            err_status,   // error levels
	output logic                             irq,          // interrupt
	output engine_status_pkg::mem_write_s    mem_wr,       // page write
	output logic                             mem_valid,    // write request
	input  wire logic                        mem_ack,      // write taken
	input  wire logic                        cmd_valid,    // command op
	input  wire logic                        cmd_posted,   // 1 = posted
	output logic                             cmd_ready,    // may accept
	output logic                             op_start,     // op issue pulse
	input  wire logic                        op_done       // op complete
);
	import engine_status_pkg::*;

	typedef enum logic [1:0] {
		SW_IDLE = 2'b01,
		SW_BUSY = 2'b10
	} page_state_e;

	typedef enum logic [1:0] {
		CMD_IDLE = 2'b01,
		CMD_WAIT = 2'b10
	} cmd_state_e;

	logic [31:0]       page_base_r;
	logic [31:0]       isr_r;
	logic [31:0]       imr_r;
	logic [31:0]       ier_r;
	logic [31:0]       status_write_mask_reg_r;
	logic [31:0]       iir_r;
	logic [31:0]       esr_r;
	logic [31:0]       emr_r;
	logic [31:0]       eir_r;
	logic [31:0]       ctrl_r;
	logic [31:0]       sent_r;
	logic [31:0]       wr_val;
	logic [31:0]       w1c;
	logic [31:0]       ev_vec;
	logic [31:0]       lvl_vec;
	logic [31:0]       isr_nxt;
	logic [31:0]       iir_set;
	logic [31:0]       rep_mask;
	logic [31:0]       report;
	logic [31:0]       rd_nxt;
	logic [PEND_W-1:0] pend_r;
	logic [PEND_W-1:0] pend_nxt;
	logic              bus_req;
	logic              bus_wr;
	logic              accept;
	logic              done_ok;
	logic              pend_full;
	page_state_e       page_st_r;
	cmd_state_e        cmd_st_r;

	// -----------------------------------------------------------------
	// wishbone slave
	// -----------------------------------------------------------------

	// one access per request, answered the cycle after strobe
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr  = bus_req && wb_we_i;

	// byte-lane merge of the write data
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = dat[8*i +: 8];
			end
		end
		return res;
	endfunction : merge

	// write-one-to-clear pattern on enabled lanes
	assign w1c = merge(RST_ZERO, wb_dat_i, wb_sel_i);

	// acknowledge, one cycle wide
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rd_nxt = RST_ZERO;
		if (wb_adr_i == OFS_PAGE_BASE) begin
			rd_nxt = page_base_r;
		end else if (wb_adr_i == OFS_INT_STATUS) begin
			rd_nxt = isr_r;
		end else if (wb_adr_i == OFS_INT_MASK) begin
			rd_nxt = imr_r;
		end else if (wb_adr_i == OFS_INT_ENABLE) begin
			rd_nxt = ier_r;
		end else if (wb_adr_i == OFS_WRITE_MASK) begin
			rd_nxt = status_write_mask_reg_r;
		end else if (wb_adr_i == OFS_INT_IDENT) begin
			rd_nxt = iir_r;
		end else if (wb_adr_i == OFS_ERR_STATUS) begin
			rd_nxt = esr_r;
		end else if (wb_adr_i == OFS_ERR_MASK) begin
			rd_nxt = emr_r;
		end else if (wb_adr_i == OFS_ERR_IDENT) begin
			rd_nxt = eir_r;
		end else if (wb_adr_i == OFS_CONTROL) begin
			rd_nxt = ctrl_r;
		end
	end

	// read data register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wb_dat_o <= RST_ZERO;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= rd_nxt;
		end
	end

	// plain read/write configuration registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			page_base_r <= RST_ZERO;
			imr_r       <= RST_ALL_MASK;
			ier_r       <= RST_ZERO;
			status_write_mask_reg_r    <= RST_ALL_MASK;
			emr_r       <= RST_ALL_MASK;
			ctrl_r      <= RST_ZERO;
		end else if (bus_wr) begin
			if (wb_adr_i == OFS_PAGE_BASE) begin
				page_base_r <= merge(page_base_r, wb_dat_i, wb_sel_i)
					& PAGE_ALIGN; // R5
			end else if (wb_adr_i == OFS_INT_MASK) begin
				imr_r <= merge(imr_r, wb_dat_i, wb_sel_i) & ISR_VALID; // R6
			end else if (wb_adr_i == OFS_INT_ENABLE) begin
				ier_r <= merge(ier_r, wb_dat_i, wb_sel_i) & ISR_VALID; // R6
			end else if (wb_adr_i == OFS_WRITE_MASK) begin
				status_write_mask_reg_r <= merge(status_write_mask_reg_r, wb_dat_i, wb_sel_i); // R19
			end else if (wb_adr_i == OFS_ERR_MASK) begin
				emr_r <= merge(emr_r, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == OFS_CONTROL) begin
				ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i) & 32'h0000_0001;
			end
		end
	end

	// -----------------------------------------------------------------
	// error status, mask and identity chain
	// -----------------------------------------------------------------

	// sample the raw error levels
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			esr_r <= RST_ZERO;
		end else begin
			esr_r <= 32'(err_status);
		end
	end

	// unmasked errors latch; a one clears except unrecoverable bits
	assign wr_val = (bus_wr && wb_adr_i == OFS_ERR_IDENT) ?
		(w1c & ~UNRECOV_MASK) : RST_ZERO; // R15

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			eir_r <= RST_ZERO;
		end else begin
			eir_r <= (eir_r & ~wr_val) | (esr_r & ~emr_r); // R13 R15
		end
	end

	// -----------------------------------------------------------------
	// engine interrupt vector
	// -----------------------------------------------------------------

	// event pulses; media counter only exists on the media pipe
	always_comb begin
		ev_vec                = RST_ZERO;
		ev_vec[BIT_USER]      = ev_user;
		ev_vec[BIT_FLUSH]     = ev_flush;
		ev_vec[BIT_PARITY]    = ev_parity; // R11
		ev_vec[BIT_MEDIA_CNT] = ev_media_cnt && IS_MEDIA; // R10
		ev_vec[BIT_CTX_SW]    = ev_ctx_sw; // R7
		lvl_vec               = RST_ZERO;
		lvl_vec[BIT_MASTER]   = |eir_r; // R14
		lvl_vec[BIT_PAGE_FLT] = pf_pending; // R8
	end

	// sticky events clear on a one, a new event wins over the clear
	always_comb begin
		isr_nxt = isr_r & ISR_STICKY;
		if (bus_wr && wb_adr_i == OFS_INT_STATUS) begin
			isr_nxt = isr_nxt & ~w1c;
		end
		isr_nxt = (isr_nxt | ev_vec | lvl_vec) & ISR_VALID; // R6
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			isr_r <= RST_ZERO;
		end else begin
			isr_r <= isr_nxt;
		end
	end

	// identity: enabled and unmasked, fault bypasses mask in repair
	always_comb begin
		iir_set = isr_nxt & ~imr_r & ier_r;
		if (ctrl_r[BIT_REPAIR]) begin
			iir_set[BIT_PAGE_FLT] = isr_nxt[BIT_PAGE_FLT]
				&& ier_r[BIT_PAGE_FLT]; // R9
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			iir_r <= RST_ZERO;
		end else if (bus_wr && wb_adr_i == OFS_INT_IDENT) begin
			iir_r <= (iir_r & ~w1c) | iir_set;
		end else begin
			iir_r <= iir_r | iir_set;
		end
	end

	// interrupt line from the identity bits
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |iir_r;
		end
	end

	// -----------------------------------------------------------------
	// status page writer
	// -----------------------------------------------------------------

	// only master error and render parity may ever be reported
	assign rep_mask = REPORT_ALWAYS | (IS_RENDER ? REPORT_RENDER
		: RST_ZERO); // R7 R8 R10 R11 R20
	assign report   = isr_r & ~status_write_mask_reg_r & rep_mask; // R12 R19

	// one write whenever the reported vector differs from the last one sent
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			page_st_r <= SW_IDLE;
			mem_valid <= 1'b0;
			mem_wr    <= '0;
			sent_r    <= RST_ZERO;
		end else begin
			case (page_st_r)
				SW_IDLE: begin
					if (report != sent_r) begin
						mem_wr.addr      <= page_base_r + ISR_SLOT_OFS; // R2
						mem_wr.data      <= report;
						mem_wr.snoop     <= 1'b1; // R3
						mem_wr.cacheable <= 1'b1; // R3
						mem_valid        <= 1'b1;
						sent_r           <= report;
						page_st_r        <= SW_BUSY;
					end
				end
				SW_BUSY: begin
					if (mem_ack) begin
						mem_valid <= 1'b0;
						page_st_r <= SW_IDLE;
					end
				end
				default: begin
					mem_valid <= 1'b0;
					page_st_r <= SW_IDLE;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// posted and non-posted command operations
	// -----------------------------------------------------------------

	assign accept    = cmd_valid && cmd_ready;
	assign done_ok   = op_done && (pend_r != '0);
	assign pend_full = &pend_r;
	assign pend_nxt  = pend_r + PEND_W'(accept) - PEND_W'(done_ok);

	// outstanding operations, each still to complete
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pend_r   <= '0;
			op_start <= 1'b0;
		end else begin
			pend_r   <= pend_nxt; // R16
			op_start <= accept;
		end
	end

	// posted ops overlap, a non-posted op issues at once and then blocks the next command until all ops drain
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cmd_st_r  <= CMD_IDLE;
			cmd_ready <= 1'b0;
		end else begin
			case (cmd_st_r)
				CMD_IDLE: begin
					if (accept && !cmd_posted) begin // R18
						cmd_st_r  <= CMD_WAIT;
						cmd_ready <= 1'b0; // R17
					end else begin
						cmd_ready <= (pend_nxt != {PEND_W{1'b1}}) && !accept
							|| (accept && !pend_full
							&& pend_nxt != {PEND_W{1'b1}}); // R16
					end
				end
				CMD_WAIT: begin
					if (pend_nxt == '0) begin
						cmd_st_r  <= CMD_IDLE;
						cmd_ready <= 1'b1; // R17
					end
				end
				default: begin
					cmd_st_r  <= CMD_IDLE;
					cmd_ready <= 1'b0;
				end
			endcase
		end
	end

endmodule : engine_status_error_reporting

//--- tb/mem_status_partner.sv
`timescale 1ns/10ps

module mem_status_partner (
	input  wire logic                     clock,     // system clock
	input  wire logic                     reset_n,   // async reset
	input  wire engine_status_pkg::mem_write_s mem_wr, // page write
	input  wire logic                     mem_valid, // write request
	output logic                          mem_ack,   // write taken
	output logic [31:0]                   last_data, // last stored word
	output int                            n_wr       // writes taken
);
	import engine_status_pkg::*;

	logic [1:0] wait_r;

	// takes a page write after a random stall, only if it is snooped
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mem_ack   <= 1'b0;
			wait_r    <= 2'h0;
			last_data <= 32'h0000_0000;
			n_wr      <= 0;
		end else begin
			mem_ack <= 1'b0;
			if (mem_valid && !mem_ack && mem_wr.snoop && mem_wr.cacheable) begin
				if (wait_r == 2'h0) begin
					mem_ack   <= 1'b1;
					last_data <= mem_wr.data;
					n_wr      <= n_wr + 1;
					wait_r    <= 2'($urandom_range(3));
				end else begin
					wait_r <= wait_r - 2'h1;
				end
			end
		end
	end

endmodule : mem_status_partner

//--- tb/engine_status_chk.sv
`timescale 1ns/10ps

module engine_status_chk #(
	parameter bit IS_RENDER = 1'b1 // engine reports parity
) (
	input wire logic                     clock,      // system clock
	input wire logic                     reset_n,    // async reset
	input wire logic                     wb_cyc_i,   // bus cycle
	input wire logic                     wb_stb_i,   // strobe
	input wire logic                     wb_ack_o,   // acknowledge
	input wire engine_status_pkg::mem_write_s mem_wr, // page write
	input wire logic                     mem_valid,  // write request
	input wire logic                     mem_ack,    // write taken
	input wire logic                     cmd_valid,  // command op
	input wire logic                     cmd_posted, // posted mode
	input wire logic                     cmd_ready,  // may accept
	input wire logic                     op_start,   // op issue pulse
	input wire logic                     op_done     // op complete
);
	import engine_status_pkg::*;

	localparam logic [31:0] REPORTABLE =
		REPORT_ALWAYS | (IS_RENDER ? REPORT_RENDER : 32'h0000_0000);

	logic [7:0] out_cnt_r;

	// outstanding ops, counted at the take edge
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			out_cnt_r <= 8'h00;
		end else begin
			out_cnt_r <= out_cnt_r + 8'(cmd_valid && cmd_ready)
				- 8'(op_done && out_cnt_r != 8'h00);
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence take_np;
		cmd_valid && cmd_ready && !cmd_posted;
	endsequence
	sequence take_p;
		cmd_valid && cmd_ready && cmd_posted && out_cnt_r == 8'h00;
	endsequence

	AST_NP_BLOCK: assert property (take_np |=> op_start && !cmd_ready)
		else $error("non-posted op did not block");
	AST_P_GO: assert property (take_p |=> op_start && cmd_ready)
		else $error("posted op stalled commands");
	AST_NP_WAIT: assert property
		(!cmd_ready && !op_done && out_cnt_r != 8'h00 |=> !cmd_ready)
		else $error("ready returned with ops outstanding");
	AST_NP_DONE: assert property
		(!cmd_ready && op_done && out_cnt_r == 8'h01 |=> cmd_ready)
		else $error("ready not back after last op done");
	AST_SNOOP: assert property (mem_valid |-> mem_wr.snoop && mem_wr.cacheable)
		else $error("page write not snooped and cacheable");
	AST_REPORT_BITS: assert property
		(mem_valid |-> (mem_wr.data & ~REPORTABLE) == 32'h0000_0000)
		else $error("unreportable bit in page write");
	AST_PAGE_ADDR: assert property (mem_valid |-> mem_wr.addr[11:0] == 12'h000)
		else $error("page write not at page base");
	AST_WR_HOLD: assert property
		(mem_valid && !mem_ack |=> mem_valid && $stable(mem_wr))
		else $error("page write changed before accept");
	AST_WR_DROP: assert property (mem_valid && mem_ack |=> !mem_valid)
		else $error("page write held after accept");
	AST_BUS_ACK: assert property
		(wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("register access ack wrong");

endmodule : engine_status_chk

bind engine_status_error_reporting engine_status_chk #(
	.IS_RENDER(IS_RENDER)
) i_engine_status_chk (.clock, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.mem_wr, .mem_valid, .mem_ack, .cmd_valid, .cmd_posted, .cmd_ready,
	.op_start, .op_done);

//--- tb/engine_status_error_reporting_tb.sv
`timescale 1ns/10ps

module engine_status_error_reporting_tb;
	import engine_status_pkg::*;

	logic        clock = 1'b0, reset_n = 1'b0, wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_dat, last_data;
	logic        ev_user = 0, ev_flush = 0, ev_parity = 0, ev_media_cnt = 0;
	logic        ev_ctx_sw = 0, pf_pending = 0, mem_valid, mem_ack, p, np_prev;
	logic        cmd_valid = 0, cmd_posted = 0, cmd_ready, op_start, op_done = 0;
	logic [15:0] err_status = 16'h0, e, m;
	logic [31:0] ev_bit [5] = '{32'h1, 32'h10, 32'h20, 32'h0, 32'h100};
	mem_write_s  mem_wr;
	int          n_wr, n0, fails = 0, n_checks = 0, cycles = 0;
	int          starts = 0, dones = 0;

	engine_status_error_reporting i_engine_status_error_reporting (.*);
	mem_status_partner i_mem_status_partner (.clock, .reset_n, .mem_wr,
		.mem_valid, .mem_ack, .last_data, .n_wr);

	always #2.5 clock = ~clock;

	// op completion with random delay, one per started op
	always @(posedge clock) begin
		if (op_start) starts = starts + 1;
		if (starts > dones && !op_done && $urandom_range(3) == 0) begin
			op_done <= 1'b1;
			dones = dones + 1;
		end else begin
			op_done <= 1'b0;
		end
	end

	// hang guard
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			finish_test();
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		rd_dat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, rd_dat, exp);
	endtask : rd_chk

	task settle;
		repeat (16) @(posedge clock);
	endtask : settle

	task pulse(input logic [4:0] v);
		@(posedge clock);
		{ev_ctx_sw, ev_media_cnt, ev_parity, ev_flush, ev_user} <= v;
		@(posedge clock);
		{ev_ctx_sw, ev_media_cnt, ev_parity, ev_flush, ev_user} <= 5'h00;
	endtask : pulse

	task cmd(input logic posted);
		@(posedge clock);
		cmd_valid  <= 1'b1;
		cmd_posted <= posted;
		do @(posedge clock); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
	endtask : cmd

	task finish_test;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(12));
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		rd_chk(OFS_INT_MASK, RST_ALL_MASK, "int mask");
		rd_chk(OFS_WRITE_MASK, RST_ALL_MASK, "write mask");
		rd_chk(8'hfc, RST_ZERO, "unmapped");
		wb(1'b1, OFS_PAGE_BASE, 32'h1234_5fff);
		rd_chk(OFS_PAGE_BASE, 32'h1234_5000, "page base");
		wb(1'b1, OFS_ERR_STATUS, 32'h0000_ffff);
		rd_chk(OFS_ERR_STATUS, RST_ZERO, "err status ro");
		wb(1'b1, OFS_INT_ENABLE, ISR_VALID);
		wb(1'b1, OFS_INT_MASK, RST_ZERO);
		wb(1'b1, OFS_WRITE_MASK, RST_ZERO);
		// error chain, last round unrecoverable
		for (int i = 0; i < 4; i++) begin
			m = 16'($urandom()) & 16'hfffc;
			e = 16'($urandom()) | 16'h0002;
			e[0] = (i == 3);
			wb(1'b1, OFS_ERR_MASK, {16'h0, m});
			err_status <= e;
			settle();
			rd_chk(OFS_ERR_STATUS, {16'h0, e}, "err status");
			rd_chk(OFS_ERR_IDENT, {16'h0, e & ~m}, "err ident");
			chk("irq", irq, 1'b1);
			chk("page master", last_data[3], 1'b1);
			err_status <= 16'h0;
			settle();
			wb(1'b1, OFS_ERR_IDENT, 32'h0000_ffff);
			settle();
			rd_chk(OFS_ERR_IDENT, {31'h0, e[0]}, "err ident clear");
			chk("page master clear", last_data[3], e[0]);
		end
		// each event source into status and page report
		for (int k = 0; k < 5; k++) begin
			pulse(5'(1 << k));
			settle();
			wb(1'b0, OFS_INT_STATUS, 32'h0);
			chk("isr event", rd_dat & ~32'h8, ev_bit[k]);
			chk("page report", last_data, 32'h8 | (k == 2 ? 32'h20 : 32'h0));
			wb(1'b1, OFS_INT_STATUS, 32'h0000_01ff);
			settle();
		end
		// page fault under mask, then with repair mode
		wb(1'b1, OFS_INT_ENABLE, 32'h0000_0080);
		wb(1'b1, OFS_INT_MASK, RST_ALL_MASK);
		wb(1'b1, OFS_INT_IDENT, 32'hffff_ffff);
		pf_pending <= 1'b1;
		settle();
		chk("irq masked", irq, 1'b0);
		rd_chk(OFS_INT_STATUS, 32'h0000_0088, "isr fault");
		wb(1'b1, OFS_CONTROL, 32'h0000_0001);
		settle();
		chk("irq repair", irq, 1'b1);
		// masked status bit makes no page write
		pf_pending <= 1'b0;
		wb(1'b1, OFS_WRITE_MASK, 32'h0000_0020);
		settle();
		n0 = n_wr;
		pulse(5'h04);
		settle();
		chk("masked write", n_wr, n0);
		// random posted and non-posted commands
		np_prev = 1'b0;
		for (int i = 0; i < 24; i++) begin
			p = (i % 6 == 5) ? 1'b0 : 1'($urandom_range(1));
			cmd(p);
			if (np_prev) chk("ops drained", dones, starts);
			np_prev = !p;
		end
		for (int i = 0; i < 200 && dones != starts; i++) @(posedge clock);
		settle();
		chk("ops paired", dones, starts);
		finish_test();
	end

endmodule : engine_status_error_reporting_tb
